// *** hw/tcp_timer.v ***
// Two-channel timer with modulo counter, compare, capture and buffered PWM behind AXI4-Lite.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "tcp_consts.vh"

// What this block does
// RL1: Unbuffered compare uses the value as written now; a skipped value misses that period.
// RL2: Compare flag rises at pulse end; overflow flag rises at period end.
// RL3: Software writes shorter widths from compare handler, longer from overflow handler.
// RL4: Software should not use toggle-on-compare for PWM.
// RL5: Buffered select on channel 0 links both channels onto channel 0 pin, channel 0 first.
// RL6: In buffered mode the last written pair takes control at each overflow.
// RL7: In buffered mode channel 1 control is unused and its pin is released.
// RL8: Software writes only the inactive pair in buffered mode.
// RL9: Software initialises: halt and reset, period, width, mode bits, then release halt.
// RL10: Mode pair 0:1 selects unbuffered, 1:0 buffered compare or PWM.
// RL11: Edge/level pair 1:0 clears output on compare, 1:1 sets it.
// RL12: Buffered select of channel 0 beats its unbuffered select.
// RL13: Output toggles at overflow only with toggle-on-overflow; otherwise 0% duty.
// RL14: Full-duty plus toggle-on-overflow gives constant 100% duty.
// RL15: Overflow flag sets on reaching modulo; request gated by its enable.
// RL16: Channel flag sets on capture or compare; request gated by channel enable.
// RL17: In wait mode timer runs, registers refuse access, enabled requests wake.
// RL18: In stop mode timer halts and keeps all state, resuming afterwards.
// RL19: Debug break freezes counter and suppresses captures.
// RL20: During break, status clears only with break-clear enable set; otherwise untouched.
// RL21: First clear step before break holds during break; second step after clears.
// RL22: No external prescaler clock; each pin is capture or compare independently.
// RL23: Prescale codes 0 to 6 divide by 1 to 64; code 7 is unused.
// RL24: After reaching modulo the counter restarts from zero next timer clock.
// RL25: Pulse width runs from overflow to the channel compare match.
// RL26: Overflow flag clears by read with flag set then write 0; new overflow keeps it.
// RL27: A value pair write completes only when its low byte is written.
module tcp_timer #(
  parameter CW = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire awvalid,
  output wire awready,
  input wire [`TCP_ADDR_W-1:0] awaddr,
  input wire [2:0] awprot,
  input wire wvalid,
  output wire wready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  output reg bvalid,
  input wire bready,
  output reg [1:0] bresp,
  input wire arvalid,
  output wire arready,
  input wire [`TCP_ADDR_W-1:0] araddr,
  input wire [2:0] arprot,
  output reg rvalid,
  input wire rready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  input wire wait_mode,
  input wire stop_mode,
  input wire dbg_break,
  input wire break_clear_enable,
  input wire [1:0] chan_pin_i,
  output wire [1:0] chan_pin_o,
  output wire [1:0] chan_pin_oen,
  output reg irq_overflow,
  output reg [1:0] irq_channel,
  output reg wake_req
);

  reg [1:0] pin_s1_r;
  reg [1:0] pin_s2_r;
  reg [1:0] pin_s3_r;
  reg ovf_flag_r;
  reg ovf_ie_r;
  reg halt_r;
  reg [2:0] ps_r;
  reg ovf_arm_r;
  reg [CW-1:0] mod_r;
  reg mod_inhib_r;
  reg [CW-1:0] cnt_r;
  reg [`TCP_PSC_W-1:0] psc_r;
  reg [15:0] csc_r;
  reg [1:0] chan_arm_r;
  reg [2*CW-1:0] cval_r;
  reg [1:0] out_r;
  reg act_sel_r;
  reg last_sel_r;
  reg aw_got_r;
  reg [`TCP_ADDR_W-1:0] awaddr_r;
  reg w_got_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;

  function [`TCP_PSC_W-1:0] psc_mask;
    input [2:0] ps;
    begin
      case (ps)
        3'h0: psc_mask = 6'h00;
        3'h1: psc_mask = 6'h01;
        3'h2: psc_mask = 6'h03;
        3'h3: psc_mask = 6'h07;
        3'h4: psc_mask = 6'h0F;
        3'h5: psc_mask = 6'h1F;
        default: psc_mask = 6'h3F;
      endcase
    end
  endfunction
  function [`TCP_ADDR_W-1:0] word_addr;
    input [`TCP_ADDR_W-1:0] a;
    begin
      word_addr = {a[`TCP_ADDR_W-1:2], 2'h0};
    end
  endfunction
  function is_mapped;
    input [`TCP_ADDR_W-1:0] a;
    begin
      case (word_addr(a))
        `TCP_OFF_TSC, `TCP_OFF_CNT, `TCP_OFF_MOD, `TCP_OFF_C0SC,
        `TCP_OFF_C0V, `TCP_OFF_C1SC, `TCP_OFF_C1V: is_mapped = 1'b1;
        default: is_mapped = 1'b0;
      endcase
    end
  endfunction
  // Channel control fields, channel 0 in the low byte.
  wire bsel0 = csc_r[`TCP_B_BSEL];
  wire [1:0] usel = {csc_r[8+`TCP_B_USEL], csc_r[`TCP_B_USEL]};
  wire [1:0] els0 = {csc_r[`TCP_B_ELH], csc_r[`TCP_B_ELL]};
  wire [1:0] els1 = {csc_r[8+`TCP_B_ELH], csc_r[8+`TCP_B_ELL]};
  wire [1:0] tov = {csc_r[8+`TCP_B_TOV], csc_r[`TCP_B_TOV]};
  wire [1:0] fmax = {csc_r[8+`TCP_B_MAX], csc_r[`TCP_B_MAX]};
  wire [1:0] cflag = {csc_r[8+`TCP_B_FLAG], csc_r[`TCP_B_FLAG]};
  wire [1:0] cie = {csc_r[8+`TCP_B_IE], csc_r[`TCP_B_IE]};

  // Buffered select wins over unbuffered select on channel 0. [RL10] [RL12]
  wire [1:0] oc_en;
  assign oc_en[0] = (els0 != `TCP_ELS_OFF) && (bsel0 || usel[0]);
  assign oc_en[1] = !bsel0 && (els1 != `TCP_ELS_OFF) && usel[1]; // [RL7]
  wire [1:0] ic_en;
  assign ic_en[0] = (els0 != `TCP_ELS_OFF) && !bsel0 && !usel[0]; // [RL22]
  assign ic_en[1] = (els1 != `TCP_ELS_OFF) && !bsel0 && !usel[1]; // [RL22]
  // The counter only advances from the bus clock; there is no outside timer clock. [RL22]
  wire run = !halt_r && !stop_mode && !dbg_break; // [RL18] [RL19]
  wire [`TCP_PSC_W-1:0] pmask = psc_mask(ps_r);
  wire tick = run && (ps_r != `TCP_PS_UNUSED) && ((psc_r & pmask) == pmask); // [RL23]
  wire [CW-1:0] cnt_nxt = (cnt_r == mod_r) ? {CW{1'b0}} : cnt_r + 1'b1; // [RL24]
  wire reach = tick && (cnt_nxt == mod_r);
  // Buffered mode compares channel 0 against whichever pair is active. [RL5] [RL6]
  wire [CW-1:0] cmp0 = (bsel0 && act_sel_r) ? cval_r[2*CW-1:CW] : cval_r[CW-1:0];
  wire [1:0] match;
  // Compare sees the value as currently written, so a jump past the count misses. [RL1] [RL25]
  assign match[0] = tick && oc_en[0] && (cnt_nxt == cmp0);
  assign match[1] = tick && oc_en[1] && (cnt_nxt == cval_r[2*CW-1:CW]);
  // Captures are held off while halted, stopped or in break. [RL19]
  wire [1:0] rise = pin_s2_r & ~pin_s3_r;
  wire [1:0] fall = ~pin_s2_r & pin_s3_r;
  wire [1:0] cap;
  assign cap[0] = run && ic_en[0] && ((els0[0] && rise[0]) || (els0[1] && fall[0]));
  assign cap[1] = run && ic_en[1] && ((els1[0] && rise[1]) || (els1[1] && fall[1]));
  wire [1:0] chan_set = match | cap; // [RL16] [RL2]
  wire ovf_set = reach && !mod_inhib_r; // [RL15] [RL2]
  // Bus handshakes; one write and one read at a time.
  assign awready = !aw_got_r && !bvalid;
  assign wready = !w_got_r && !bvalid;
  assign arready = !rvalid;
  wire wr_fire = aw_got_r && w_got_r && !bvalid;
  wire wr_ok = wr_fire && !wait_mode && is_mapped(awaddr_r); // [RL17]
  wire [`TCP_ADDR_W-1:0] wa = word_addr(awaddr_r);
  wire rd_fire = arvalid && !rvalid;
  wire rd_ok = rd_fire && !wait_mode && is_mapped(araddr); // [RL17]
  wire [`TCP_ADDR_W-1:0] ra = word_addr(araddr);
  // In break with clearing disabled, accesses leave status untouched. [RL20]
  wire clr_ok = !dbg_break || break_clear_enable;
  wire b0 = wstrb_r[0];
  wire b1 = wstrb_r[1];
  wire w_tsc = wr_ok && (wa == `TCP_OFF_TSC) && b0;
  wire w_c0sc = wr_ok && (wa == `TCP_OFF_C0SC) && b0;
  wire w_c1sc = wr_ok && (wa == `TCP_OFF_C1SC) && b0 && !bsel0; // [RL7]
  wire [1:0] w_cv_lo;
  assign w_cv_lo[0] = wr_ok && (wa == `TCP_OFF_C0V) && b0;
  assign w_cv_lo[1] = wr_ok && (wa == `TCP_OFF_C1V) && b0;
  wire [1:0] w_cv_hi;
  assign w_cv_hi[0] = wr_ok && (wa == `TCP_OFF_C0V) && b1;
  assign w_cv_hi[1] = wr_ok && (wa == `TCP_OFF_C1V) && b1;
  wire crst = w_tsc && wdata_r[`TCP_B_CRST];
  // Second step of the flag clear: write 0 after an armed read. [RL26] [RL21]
  wire ovf_clr = w_tsc && !wdata_r[`TCP_B_FLAG] && ovf_arm_r && clr_ok;
  wire [1:0] chan_clr;
  assign chan_clr[0] = w_c0sc && !wdata_r[`TCP_B_FLAG] && chan_arm_r[0] && clr_ok;
  assign chan_clr[1] = w_c1sc && !wdata_r[`TCP_B_FLAG] && chan_arm_r[1] && clr_ok;
  wire ovf_arm_set = rd_ok && (ra == `TCP_OFF_TSC) && ovf_flag_r && clr_ok;
  wire [1:0] chan_arm_set;
  assign chan_arm_set[0] = rd_ok && (ra == `TCP_OFF_C0SC) && cflag[0] && clr_ok;
  assign chan_arm_set[1] = rd_ok && (ra == `TCP_OFF_C1SC) && cflag[1] && clr_ok && !bsel0;

  // Output next state for both channels.
  reg [1:0] out_nxt;
  reg [1:0] els_i;
  reg v;
  integer i;
  integer j;
  always @* begin
    out_nxt = out_r;
    els_i = `TCP_ELS_OFF;
    v = 1'b0;
    for (i = 0; i < 2; i = i + 1) begin
      els_i = (i == 0) ? els0 : els1;
      v = out_r[i];
      if (els_i == `TCP_ELS_OFF) begin
        v = !usel[i];
      end else if (oc_en[i]) begin
        if (fmax[i] && tov[i]) begin
          v = !els_i[0]; // [RL14]
        end else begin
          if (reach && tov[i]) begin
            v = !v; // [RL13]
          end
          if (match[i]) begin
            case (els_i)
              `TCP_ELS_TOG: v = !v;
              `TCP_ELS_CLR: v = 1'b0; // [RL11]
              `TCP_ELS_SET: v = 1'b1; // [RL11]
              default: v = v;
            endcase
          end
        end
      end
      out_nxt[i] = v;
    end
  end

  // Pins are driven only in compare mode; oen low means driving.
  assign chan_pin_o = out_r;
  assign chan_pin_oen = ~oc_en; // [RL5] [RL7]

  // Read data mux.
  reg [31:0] rd_val;
  always @* begin
    rd_val = 32'h00000000;
    case (ra)
      `TCP_OFF_TSC: rd_val[7:0] = {ovf_flag_r, ovf_ie_r, halt_r, 2'h0, ps_r};
      `TCP_OFF_CNT: rd_val[CW-1:0] = cnt_r;
      `TCP_OFF_MOD: rd_val[CW-1:0] = mod_r;
      `TCP_OFF_C0SC: rd_val[7:0] = csc_r[7:0];
      `TCP_OFF_C0V: rd_val[CW-1:0] = cval_r[CW-1:0];
      `TCP_OFF_C1SC: rd_val[7:0] = bsel0 ? 8'h00 : csc_r[15:8]; // [RL7]
      `TCP_OFF_C1V: rd_val[CW-1:0] = cval_r[2*CW-1:CW];
      default: rd_val = 32'h00000000;
    endcase
  end

  // Pin synchronisers; the first stage feeds only the second.
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= 2'h0;
      pin_s2_r <= 2'h0;
      pin_s3_r <= 2'h0;
    end else begin
      pin_s1_r <= chan_pin_i;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // Bus channel state.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      awaddr_r <= `TCP_OFF_TSC;
      w_got_r <= 1'b0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `TCP_RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `TCP_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? `TCP_RESP_OKAY : `TCP_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (rd_fire) begin
        rvalid <= 1'b1;
        rdata <= rd_ok ? rd_val : 32'h00000000;
        rresp <= rd_ok ? `TCP_RESP_OKAY : `TCP_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Timer core and registers. Stop mode only gates the advance, so every value is kept. [RL18]
  always @(posedge aclk) begin
    if (!aresetn) begin
      ovf_flag_r <= 1'b0;
      ovf_ie_r <= 1'b0;
      halt_r <= 1'b1;
      ps_r <= 3'h0;
      ovf_arm_r <= 1'b0;
      mod_r <= `TCP_MOD_RST;
      mod_inhib_r <= 1'b0;
      cnt_r <= `TCP_CNT_ZERO;
      psc_r <= 6'h00;
      csc_r <= 16'h0000;
      chan_arm_r <= 2'h0;
      cval_r <= {2*CW{1'b0}};
      out_r <= 2'h0;
      act_sel_r <= 1'b0;
      last_sel_r <= 1'b0;
      irq_overflow <= 1'b0;
      irq_channel <= 2'h0;
      wake_req <= 1'b0;
    end else begin
      // Counter reset also clears the prescaler and wins over counting.
      if (crst) begin
        cnt_r <= `TCP_CNT_ZERO;
        psc_r <= 6'h00;
      end else if (run) begin
        psc_r <= psc_r + 1'b1;
        if (tick) begin
          cnt_r <= cnt_nxt; // [RL24]
        end
      end
      if (w_tsc) begin
        ovf_ie_r <= wdata_r[`TCP_B_IE];
        halt_r <= wdata_r[`TCP_B_HALT];
        ps_r <= wdata_r[`TCP_PS_HI:`TCP_PS_LO];
      end
      // Set beats clear, and a new overflow disarms the pending clear. [RL26]
      ovf_flag_r <= ovf_set || (ovf_flag_r && !ovf_clr); // [RL15]
      ovf_arm_r <= !ovf_set && !ovf_clr && (ovf_arm_r || ovf_arm_set); // [RL21]
      // A high byte alone holds off the overflow flag until the low byte lands.
      if (wr_ok && (wa == `TCP_OFF_MOD)) begin
        if (b0) begin
          mod_r[7:0] <= wdata_r[7:0];
        end
        if (b1) begin
          mod_r[CW-1:8] <= wdata_r[CW-1:8];
        end
        mod_inhib_r <= b1 && !b0;
      end
      if (w_c0sc) begin
        csc_r[6:0] <= wdata_r[6:0];
      end
      if (w_c1sc) begin
        csc_r[14:8] <= {wdata_r[6], 1'b0, wdata_r[4:0]};
      end
      csc_r[`TCP_B_FLAG] <= chan_set[0] || (cflag[0] && !chan_clr[0]); // [RL16]
      csc_r[8+`TCP_B_FLAG] <= chan_set[1] || (cflag[1] && !chan_clr[1]); // [RL16]
      chan_arm_r <= ~chan_set & ~chan_clr & (chan_arm_r | chan_arm_set); // [RL21]
      // Channel values: a capture wins over a write in the same cycle.
      for (j = 0; j < 2; j = j + 1) begin
        if (cap[j]) begin
          cval_r[j*CW +: CW] <= cnt_r;
        end else begin
          if (w_cv_lo[j]) begin
            cval_r[j*CW +: 8] <= wdata_r[7:0];
          end
          if (w_cv_hi[j]) begin
            cval_r[j*CW+8 +: CW-8] <= wdata_r[CW-1:8];
          end
        end
      end
      // Only a low byte write marks a pair as last written. [RL27]
      if (!bsel0) begin
        last_sel_r <= 1'b0;
      end else if (w_cv_lo[1]) begin
        last_sel_r <= 1'b1; // [RL6]
      end else if (w_cv_lo[0]) begin
        last_sel_r <= 1'b0; // [RL6]
      end
      // Channel 0 owns the output until an overflow hands over. [RL5]
      if (!bsel0) begin
        act_sel_r <= 1'b0;
      end else if (reach) begin
        act_sel_r <= w_cv_lo[1] ? 1'b1 : (w_cv_lo[0] ? 1'b0 : last_sel_r); // [RL6]
      end
      out_r <= out_nxt;
      irq_overflow <= ovf_flag_r && ovf_ie_r; // [RL15]
      irq_channel <= cflag & cie; // [RL16]
      // Wait mode keeps the timer running; any enabled request wakes the core. [RL17]
      wake_req <= wait_mode && ((ovf_flag_r && ovf_ie_r) || |(cflag & cie));
    end
  end

endmodule

// *** include/tcp_consts.vh ***
// Constants for the two-channel timer and PWM block.
`ifndef TCP_CONSTS_VH
`define TCP_CONSTS_VH
`define TCP_ADDR_W 8
`define TCP_OFF_TSC 8'h00
`define TCP_OFF_CNT 8'h04
`define TCP_OFF_MOD 8'h08
`define TCP_OFF_C0SC 8'h0C
`define TCP_OFF_C0V 8'h10
`define TCP_OFF_C1SC 8'h14
`define TCP_OFF_C1V 8'h18
`define TCP_B_FLAG 7
`define TCP_B_IE 6
`define TCP_B_HALT 5
`define TCP_B_CRST 4
`define TCP_PS_HI 2
`define TCP_PS_LO 0
`define TCP_B_BSEL 5
`define TCP_B_USEL 4
`define TCP_B_ELH 3
`define TCP_B_ELL 2
`define TCP_B_TOV 1
`define TCP_B_MAX 0
`define TCP_MOD_RST 16'hFFFF
`define TCP_CNT_ZERO 16'h0000
`define TCP_PS_UNUSED 3'h7
`define TCP_PSC_W 6
`define TCP_ELS_OFF 2'h0
`define TCP_ELS_TOG 2'h1
`define TCP_ELS_CLR 2'h2
`define TCP_ELS_SET 2'h3
`define TCP_RESP_OKAY 2'h0
`define TCP_RESP_SLVERR 2'h2
`endif

// *** verif/tcp_chk.sv ***
// Concurrent checks on the timer block's bus and pin ports.
`timescale 1ns/1ns
`include "tcp_consts.vh"
module tcp_chk (
  input wire aclk,
  input wire aresetn,
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire bvalid,
  input wire arvalid,
  input wire arready,
  input wire [`TCP_ADDR_W-1:0] araddr,
  input wire rvalid,
  input wire rready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire wait_mode,
  input wire stop_mode,
  input wire dbg_break,
  input wire [1:0] chan_pin_o,
  input wire wake_req
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_rd_take;
    arvalid && arready;
  endsequence
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  a_rd_latency: assert property (s_rd_take |=> rvalid) else $error("read answer late");
  a_wr_latency: assert property (s_wr_take |-> ##2 bvalid) else $error("write answer late");
  a_wait_refuse: assert property (s_rd_take ##0 wait_mode |=> rresp == `TCP_RESP_SLVERR)
    else $error("access taken in wait mode");
  a_wake_cause: assert property (wake_req |-> $past(wait_mode))
    else $error("wake request outside wait mode");
  a_stop_hold: assert property (stop_mode && $past(stop_mode) |-> $stable(chan_pin_o))
    else $error("output moved in stop mode");
  a_break_hold: assert property (dbg_break [*2] |-> $stable(chan_pin_o))
    else $error("output moved in break");
  a_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data dropped");
  a_bus_block: assert property (bvalid |-> !awready && !wready) else $error("write taken during response");
  a_unmapped_rd: assert property (s_rd_take ##0 (araddr > 8'h1B) |=> rresp == `TCP_RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read accepted");
endmodule
bind tcp_timer tcp_chk u_chk (.*);

// *** verif/tcp_host.sv ***
// Host model issuing AXI4-Lite register cycles to the timer.
`timescale 1ns/1ns
module tcp_host (
  input wire aclk,
  output logic awvalid,
  input wire awready,
  output logic [7:0] awaddr,
  output logic wvalid,
  input wire wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire bvalid,
  output logic bready,
  input wire [1:0] bresp,
  output logic arvalid,
  input wire arready,
  output logic [7:0] araddr,
  input wire rvalid,
  output logic rready,
  input wire [31:0] rdata,
  input wire [1:0] rresp
);
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
  end
  // Released lines show the inverse so a late sample cannot pass by luck.
  task automatic wr(input [7:0] a, input [31:0] d, output [1:0] r);
    bit ta, tw;
    ta = 0;
    tw = 0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ta = 1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        tw = 1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input [7:0] a, output [31:0] d, output [1:0] r);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    do @(posedge aclk); while (!rvalid);
    // One cycle of back-pressure, so the design must hold its answer.
    rready <= 1'b1;
    @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the two-channel timer and PWM block.
`timescale 1ns/1ns
`include "tcp_consts.vh"
module tb;
  logic aclk = 0, aresetn = 0, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, c;
  logic [3:0] wstrb;
  logic [2:0] awprot, arprot;
  logic [1:0] bresp, rresp, s, chan_pin_o, chan_pin_oen, irq_channel, pin_ext;
  logic wait_mode, stop_mode, dbg_break, break_clear_enable, irq_overflow, wake_req;
  int errors, n_checks, base_hi, h, p;
  wire [1:0] chan_pin_i = (~chan_pin_oen & chan_pin_o) | (chan_pin_oen & pin_ext);
  tcp_timer uut (.*);
  tcp_host hm (.*);
  always #25 aclk = ~aclk;
  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic w(input [7:0] a, input [31:0] v);
    hm.wr(a, v, s);
    chk(s === `TCP_RESP_OKAY, "write refused");
  endtask
  // Halt and reset first, so no compare fires on a half-written setup.
  task automatic cfg(input [15:0] m, input [15:0] v, input [7:0] cs);
    w(`TCP_OFF_TSC, 32'h30);
    w(`TCP_OFF_MOD, {16'h0, m});
    w(`TCP_OFF_C0V, {16'h0, v});
    w(`TCP_OFF_C0SC, {24'h0, cs});
    w(`TCP_OFF_TSC, 32'h0);
  endtask
  // High time and period between two rises; measured twice inside to skip a partial period.
  task automatic meas;
    int n;
    n = 0;
    repeat (2) begin
      while (chan_pin_o[0] !== 1'b0 && n < 3000) begin @(posedge aclk); n++; end
      while (chan_pin_o[0] !== 1'b1 && n < 3000) begin @(posedge aclk); n++; end
      h = 0;
      while (chan_pin_o[0] === 1'b1 && n < 3000) begin @(posedge aclk); h++; n++; end
      p = h;
      while (chan_pin_o[0] !== 1'b1 && n < 3000) begin @(posedge aclk); p++; n++; end
    end
    chk(n < 3000, "pin stuck");
  endtask
  task automatic steady(input logic v);
    bit ok;
    ok = 1;
    repeat (25) begin @(posedge aclk); if (chan_pin_o[0] !== v) ok = 0; end
    chk(ok, "level not steady");
  endtask
  task automatic t_reset;
    hm.rd(`TCP_OFF_TSC, d, s);
    chk(d[7:0] === 8'h20, "status reset value");
    hm.rd(`TCP_OFF_MOD, d, s);
    chk(d[15:0] === `TCP_MOD_RST, "modulo reset value");
    hm.rd(8'h1C, d, s);
    chk(s === `TCP_RESP_SLVERR, "unmapped read accepted");
  endtask
  task automatic t_pwm;
    cfg(16'h9, 16'h3, 8'h1A);
    meas;
    chk(p == 10, "period");
    chk(chan_pin_oen[0] === 1'b0, "pin not driven");
    base_hi = h;
    w(`TCP_OFF_C0V, 32'h6);
    meas;
    chk(h == base_hi + 3, "pulse width");
    cfg(16'h9, 16'h3, 8'h1E);
    meas;
    chk(h == 10 - base_hi, "set on compare");
    for (int k = 1; k < 7; k++) begin
      w(`TCP_OFF_TSC, 32'(k));
      meas;
      chk(p == (10 << k), "prescaled period");
    end
  endtask
  task automatic t_duty;
    cfg(16'h9, 16'h3, 8'h18);
    repeat (12) @(posedge aclk);
    steady(1'b0);
    cfg(16'h9, 16'h3, 8'h1B);
    repeat (12) @(posedge aclk);
    steady(1'b1);
  endtask
  task automatic t_buf;
    cfg(16'h9, 16'h3, 8'h3A);
    meas;
    chk(h == base_hi, "channel 0 not first");
    w(`TCP_OFF_C1V, 32'h6);
    meas;
    chk(h == base_hi + 3, "channel 1 not in control");
    chk(chan_pin_oen[1] === 1'b1, "channel 1 pin held");
    w(`TCP_OFF_C1SC, 32'h1A);
    hm.rd(`TCP_OFF_C1SC, d, s);
    chk(d === 32'h0, "channel 1 control live");
  endtask
  task automatic t_flag;
    w(`TCP_OFF_TSC, 32'h0);
    repeat (12) @(posedge aclk);
    chk(irq_overflow === 1'b0, "masked request");
    w(`TCP_OFF_TSC, 32'h60);
    repeat (3) @(posedge aclk);
    chk(irq_overflow === 1'b1, "request missing");
    hm.rd(`TCP_OFF_TSC, d, s);
    chk(d[7] === 1'b1, "flag not set");
    dbg_break <= 1'b1;
    w(`TCP_OFF_TSC, 32'h60);
    repeat (3) @(posedge aclk);
    chk(irq_overflow === 1'b1, "flag cleared in break");
    dbg_break <= 1'b0;
    w(`TCP_OFF_TSC, 32'h60);
    repeat (3) @(posedge aclk);
    chk(irq_overflow === 1'b0, "flag not cleared");
  endtask
  task automatic t_lowpow;
    w(`TCP_OFF_TSC, 32'h40);
    repeat (12) @(posedge aclk);
    wait_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(wake_req === 1'b1, "no wake");
    hm.rd(`TCP_OFF_TSC, d, s);
    chk(s === `TCP_RESP_SLVERR, "access in wait");
    wait_mode <= 1'b0;
    stop_mode <= 1'b1;
    repeat (2) @(posedge aclk);
    hm.rd(`TCP_OFF_CNT, c, s);
    repeat (5) @(posedge aclk);
    hm.rd(`TCP_OFF_CNT, d, s);
    chk(d === c, "counter ran in stop");
    stop_mode <= 1'b0;
    repeat (3) @(posedge aclk);
    hm.rd(`TCP_OFF_CNT, d, s);
    chk(d !== c, "counter did not resume");
  endtask
  // Unlinked channel 1 as a rising-edge capture; an edge seen in break is lost for good.
  task automatic t_cap;
    w(`TCP_OFF_TSC, 32'h30);
    w(`TCP_OFF_C0SC, 32'h1A);
    w(`TCP_OFF_C1SC, 32'h1A);
    chk(chan_pin_oen[1] === 1'b0, "channel 1 pin not driven");
    w(`TCP_OFF_C0SC, 32'h3A);
    chk(chan_pin_oen[1] === 1'b1, "linked channel 1 pin driven");
    w(`TCP_OFF_C0SC, 32'h1A);
    w(`TCP_OFF_C1SC, 32'h44);
    dbg_break <= 1'b1;
    w(`TCP_OFF_TSC, 32'h0);
    pin_ext <= 2'h2;
    repeat (6) @(posedge aclk);
    chk(irq_channel === 2'h0, "capture in break");
    dbg_break <= 1'b0;
    pin_ext <= 2'h0;
    repeat (4) @(posedge aclk);
    pin_ext <= 2'h2;
    repeat (6) @(posedge aclk);
    chk(irq_channel === 2'h2, "capture request missing");
    hm.rd(`TCP_OFF_C1SC, d, s);
    chk(d[7] === 1'b1, "capture flag");
    w(`TCP_OFF_C1SC, 32'h44);
    repeat (2) @(posedge aclk);
    chk(irq_channel === 2'h0, "channel flag not cleared");
  endtask
  initial begin
    {awprot, arprot, wait_mode, stop_mode, dbg_break, break_clear_enable, pin_ext} = 12'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_pwm;
    t_duty;
    t_buf;
    t_flag;
    t_lowpow;
    t_cap;
    finish_test;
  end
  initial begin
    repeat (40000) @(posedge aclk);
    errors++;
    finish_test;
  end
endmodule
